// file: design/rtsp_device.sv
// Device end of the three-wire serial link with a small register file.
module rtsp_device
    import rtsp_pkg::*;
#(
    parameter int WDOG_CYCLES = RTSP_WDOG_CYCLES
) (
    input  wire logic                    clock,
    input  wire logic                    resetn,
    rtsp_if.device                       link,
    input  wire logic [RTSP_ADDR_BITS-1:0] user_rd_index,
    output logic      [7:0]              user_rd_data,
    output logic                         counting_frozen,
    output logic                         watchdog_fired
);
    typedef struct packed {
        logic [1:0]                cs_sync;
        logic [1:0]                sck_sync;
        logic [1:0]                sdi_sync;
        logic                      sck_prev;
        logic                      sampled;
        logic [7:0]                shift;
        logic [2:0]                bitcnt;
        logic                      have_cmd;
        logic                      dir;
        logic                      ignore;
        logic                      locked;
        logic [RTSP_ADDR_BITS-1:0] addr;
        logic [7:0]                tx;
        logic                      oe;
        logic [31:0]               wdog;
        logic                      fired;
        logic [RTSP_NUM_REGS-1:0][7:0] regs;
    } rtsp_dev_state_t;

    rtsp_dev_state_t st_reg;
    rtsp_dev_state_t st_next;

    logic cs;
    logic sck;
    logic rise;
    logic fall;
    logic [7:0] byte_in;

    assign cs   = st_reg.cs_sync[1];
    assign sck  = st_reg.sck_sync[1];
    assign rise = cs && sck && !st_reg.sck_prev;
    assign fall = cs && !sck && st_reg.sck_prev;
    assign byte_in = {st_reg.shift[6:0], st_reg.sampled};

    always_comb begin
        st_next = st_reg;
        st_next.cs_sync  = {st_reg.cs_sync[0], link.chip_select};
        st_next.sck_sync = {st_reg.sck_sync[0], link.serial_clock};
        st_next.sdi_sync = {st_reg.sdi_sync[0], link.serial_data_in};
        st_next.sck_prev = sck;
        st_next.fired    = 1'b0;
        if (!cs) begin
            // Registers survive; only the interface state is cleared.
            st_next.bitcnt   = RTSP_BIT_FIRST;
            st_next.have_cmd = 1'b0;
            st_next.ignore   = 1'b0;
            st_next.locked   = 1'b0;
            st_next.oe       = 1'b0;
            st_next.wdog     = '0;
        end else if (!st_reg.locked) begin
            if (rise) begin
                st_next.sampled = st_reg.sdi_sync[1];
            end
            if (fall) begin
                st_next.shift  = byte_in;
                st_next.bitcnt = st_reg.bitcnt + 3'h1;
                if (st_reg.bitcnt == RTSP_BIT_LAST) begin
                    if (!st_reg.have_cmd) begin
                        st_next.have_cmd = 1'b1;
                        st_next.dir      = byte_in[RTSP_RW_BIT];
                        st_next.addr     = byte_in[RTSP_ADDR_BITS-1:0];
                        st_next.ignore   = byte_in[RTSP_SUB_HI:RTSP_SUB_LO]
                                           != RTSP_SUB_VALID;
                        if (byte_in[RTSP_RW_BIT] == RTSP_DIR_READ) begin
                            st_next.tx = st_reg.regs[byte_in[RTSP_ADDR_BITS-1:0]];
                        end
                    end else if (!st_reg.ignore) begin
                        if (st_reg.dir == RTSP_DIR_WRITE) begin
                            st_next.regs[st_reg.addr] = byte_in;
                        end else begin
                            st_next.tx = st_reg.regs[st_reg.addr + 4'h1];
                        end
                        st_next.addr = st_reg.addr + 4'h1;
                    end
                end else if (st_reg.have_cmd && st_reg.dir == RTSP_DIR_READ) begin
                    st_next.tx = {st_reg.tx[6:0], 1'b0};
                end
                // Drive only in a valid read data phase.
                st_next.oe = (st_reg.bitcnt == RTSP_BIT_LAST && !st_reg.have_cmd)
                           ? (byte_in[RTSP_RW_BIT] == RTSP_DIR_READ
                              && byte_in[RTSP_SUB_HI:RTSP_SUB_LO] == RTSP_SUB_VALID)
                           : st_reg.oe;
            end
            if (st_reg.have_cmd && !st_reg.ignore) begin
                // Counts only after a valid subaddress; lock until select drops.
                if (st_reg.wdog >= 32'(WDOG_CYCLES)) begin
                    st_next.locked = 1'b1;
                    st_next.oe     = 1'b0;
                    st_next.fired  = 1'b1;
                end else begin
                    st_next.wdog = st_reg.wdog + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.serial_data_out    = st_reg.tx[RTSP_BYTE_BITS-1];
    assign link.serial_data_out_oe = st_reg.oe;
    assign user_rd_data            = st_reg.regs[user_rd_index];
    // Time keeping outside would stall on this level.
    assign counting_frozen = cs && st_reg.have_cmd && !st_reg.ignore && !st_reg.locked;
    assign watchdog_fired  = st_reg.fired;
endmodule : rtsp_device

// file: design/rtsp_host.sv
// Host end: drives select, clock and data for one command plus data bytes.
module rtsp_host
    import rtsp_pkg::*;
#(
    parameter int HALF = RTSP_SCK_HALF
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    rtsp_if.host            link,
    input  wire logic       start,
    input  wire logic [7:0] cmd_byte,
    input  wire logic [3:0] data_count,
    input  wire logic [7:0] wr_data,
    output logic            busy,
    output logic            byte_pulse,
    output logic [7:0]      rd_data,
    output logic            done
);
    typedef struct packed {
        rtsp_hstate_t st;
        logic [7:0]   tx;
        logic [7:0]   rx;
        logic [2:0]   bitcnt;
        logic [3:0]   left;
        logic [7:0]   div;
        logic         cs;
        logic         sck;
        logic [1:0]   sdo_sync;
        logic [7:0]   rd;
        logic         bp;
        logic         dn;
    } rtsp_host_state_t;

    rtsp_host_state_t h_reg;
    rtsp_host_state_t h_next;

    always_comb begin
        h_next = h_reg;
        h_next.sdo_sync = {h_reg.sdo_sync[0], link.serial_data_out};
        h_next.bp = 1'b0;
        h_next.dn = 1'b0;
        h_next.div = h_reg.div + 8'h1;
        case (h_reg.st)
            RTSP_H_IDLE: begin
                h_next.div = '0;
                if (start) begin
                    h_next.st   = RTSP_H_SEL;
                    h_next.cs   = 1'b1;
                    h_next.tx   = cmd_byte;
                    h_next.left = data_count;
                    h_next.bitcnt = RTSP_BIT_FIRST;
                end
            end
            RTSP_H_SEL, RTSP_H_LOW: begin
                if (h_reg.div == 8'(HALF - 1)) begin
                    h_next.div = '0;
                    h_next.sck = 1'b1;
                    h_next.st  = RTSP_H_HIGH;
                end
            end
            RTSP_H_HIGH: begin
                if (h_reg.div == 8'(HALF - 1)) begin
                    h_next.div = '0;
                    h_next.sck = 1'b0;
                    h_next.st  = RTSP_H_LOW;
                    h_next.tx  = {h_reg.tx[6:0], 1'b0};
                    // Sampled at the end of the high phase: the device answer and the
                    // two-flop sync together need more than one half period.
                    h_next.rx  = {h_reg.rx[6:0], h_reg.sdo_sync[1]};
                    h_next.bitcnt = h_reg.bitcnt + 3'h1;
                    if (h_reg.bitcnt == RTSP_BIT_LAST) begin
                        h_next.tx = wr_data;
                        if (h_reg.st != RTSP_H_SEL && h_reg.cs) begin
                            h_next.rd = {h_reg.rx[6:0], h_reg.sdo_sync[1]};
                        end
                        h_next.bp = 1'b1;
                        if (h_reg.left == 4'h0) begin
                            h_next.st = RTSP_H_DONE;
                        end else begin
                            h_next.left = h_reg.left - 4'h1;
                        end
                    end
                end
            end
            RTSP_H_DONE: begin
                if (h_reg.div == 8'(HALF - 1)) begin
                    h_next.cs = 1'b0;
                    h_next.dn = 1'b1;
                    h_next.st = RTSP_H_IDLE;
                end
            end
            default: h_next.st = RTSP_H_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            h_reg <= '0;
        end else begin
            h_reg <= h_next;
        end
    end

    assign link.chip_select    = h_reg.cs;
    assign link.serial_clock   = h_reg.sck;
    // Data input always driven to a level, never left floating.
    assign link.serial_data_in = h_reg.tx[RTSP_BYTE_BITS-1];
    assign busy       = h_reg.st != RTSP_H_IDLE;
    assign byte_pulse = h_reg.bp;
    assign rd_data    = h_reg.rd;
    assign done       = h_reg.dn;
endmodule : rtsp_host

// file: design/rtsp_if.sv
// Interface carrying the chip select, serial clock and data lines between host and device.
interface rtsp_if;
    logic chip_select;
    logic serial_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_oe;

    modport device (
        input  chip_select,
        input  serial_clock,
        input  serial_data_in,
        output serial_data_out,
        output serial_data_out_oe
    );

    modport host (
        output chip_select,
        output serial_clock,
        output serial_data_in,
        input  serial_data_out,
        input  serial_data_out_oe
    );
endinterface : rtsp_if

// file: design/rtsp_pkg.sv
// Package of constants shared by both ends of the three-wire serial link, and of the host state type.
package rtsp_pkg;
    localparam int          RTSP_BYTE_BITS    = 8;
    localparam int          RTSP_ADDR_BITS    = 4;
    localparam int          RTSP_RW_BIT       = 7;
    localparam int          RTSP_SUB_HI       = 6;
    localparam int          RTSP_SUB_LO       = 4;
    localparam logic [2:0]  RTSP_SUB_VALID    = 3'h1;
    localparam logic        RTSP_DIR_WRITE    = 1'b0;
    localparam logic        RTSP_DIR_READ     = 1'b1;
    localparam int          RTSP_NUM_REGS     = 16;
    localparam int          RTSP_CLK_HZ       = 40_000_000;
    localparam int          RTSP_WDOG_MS      = 1000;
    localparam int          RTSP_WDOG_CYCLES  = (RTSP_CLK_HZ / 1000) * RTSP_WDOG_MS;
    localparam int          RTSP_SCK_HALF     = 4;
    localparam logic [7:0]  RTSP_REG_RESET    = 8'h00;
    localparam logic [2:0]  RTSP_BIT_LAST     = 3'h7;
    localparam logic [2:0]  RTSP_BIT_FIRST    = 3'h0;

    typedef enum logic [2:0] {
        RTSP_H_IDLE,
        RTSP_H_SEL,
        RTSP_H_LOW,
        RTSP_H_HIGH,
        RTSP_H_DONE
    } rtsp_hstate_t;
endpackage : rtsp_pkg

// file: dv/rtsp_checker.sv
// Assertions on the serial link signals between the host and device ends.
module rtsp_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    logic       sck_reg;
    logic [7:0] rise_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Rises are counted per frame so that byte framing can be judged at the select fall.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sck_reg  <= 1'b0;
            rise_reg <= 8'h00;
        end else begin
            sck_reg  <= serial_clock;
            rise_reg <= !chip_select ? 8'h00 : rise_reg + {7'h00, serial_clock & !sck_reg};
        end
    end
    property p_cs_clears_oe; !chip_select [*4] |-> !serial_data_out_oe; endproperty
    a_cs_clears_oe: assert property (p_cs_clears_oe) else $error("drive while deselected");
    property p_sck_in_frame; !chip_select |-> !serial_clock; endproperty
    a_sck_in_frame: assert property (p_sck_in_frame) else $error("clock outside frame");
    property p_whole_bytes; $fell(chip_select) |-> rise_reg[2:0] == 3'h0; endproperty
    a_whole_bytes: assert property (p_whole_bytes) else $error("partial byte framed");
    property p_sdi_stable; serial_clock && $past(serial_clock) |-> $stable(serial_data_in); endproperty
    a_sdi_stable: assert property (p_sdi_stable) else $error("data in moved while high");
    property p_sdo_on_fall;
        $changed(serial_data_out) && serial_data_out_oe && $past(serial_data_out_oe)
            |-> !serial_clock;
    endproperty
    a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("data out moved while high");
    property p_no_drive_cmd; serial_data_out_oe && chip_select |-> rise_reg >= 8'h08; endproperty
    a_no_drive_cmd: assert property (p_no_drive_cmd) else $error("drive in command byte");
    property p_high_len; $rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock; endproperty
    a_high_len: assert property (p_high_len) else $error("clock high phase length");
    property p_low_len; $fell(serial_clock) && chip_select |-> !serial_clock [*4]; endproperty
    a_low_len: assert property (p_low_len) else $error("clock low phase length");
endmodule : rtsp_checker

// file: dv/tb_top.sv
// Self-checking bench driving the host end against the device end.
module tb_top import rtsp_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clock, resetn, host_rstn, start, busy, byte_pulse, done, frz_seen;
    logic       counting_frozen, watchdog_fired;
    logic [7:0] cmd_byte, wr_data, rd_data, user_rd_data;
    logic [3:0] data_count, user_rd_index;
    int         failures, compares, wd_cnt;
    logic [7:0] q[$];
    rtsp_if link ();
    rtsp_host rtsp_host_inst (.clock(clock), .resetn(host_rstn), .link(link), .start(start),
        .cmd_byte(cmd_byte), .data_count(data_count), .wr_data(wr_data), .busy(busy),
        .byte_pulse(byte_pulse), .rd_data(rd_data), .done(done));
    // A short watchdog keeps the lock-up case inside one long read.
    rtsp_device #(.WDOG_CYCLES(600)) rtsp_device_inst (.clock(clock), .resetn(resetn),
        .link(link), .user_rd_index(user_rd_index), .user_rd_data(user_rd_data),
        .counting_frozen(counting_frozen), .watchdog_fired(watchdog_fired));
    rtsp_checker rtsp_checker_inst (.clock(clock), .resetn(resetn && host_rstn),
        .chip_select(link.chip_select), .serial_clock(link.serial_clock),
        .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
        .serial_data_out_oe(link.serial_data_out_oe));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (counting_frozen === 1'b1) frz_seen = 1'b1;
        if (watchdog_fired === 1'b1) wd_cnt++;
    end
    function automatic logic [7:0] pat(input int r);
        return 8'(r * 17) ^ 8'ha5;
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_chk(input int r, input logic [7:0] exp);
        @(negedge clock);
        user_rd_index = 4'(r);
        #1 chk("register", exp, user_rd_data);
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [3:0] n, input logic [7:0] wd);
        int i;
        q.delete();
        frz_seen = 1'b0;
        @(negedge clock);
        start = 1'b1;
        cmd_byte = cmd;
        data_count = n;
        wr_data = wd;
        @(negedge clock);
        start = 1'b0;
        for (i = 0; i < 3000 && done !== 1'b1; i++) begin
            @(negedge clock);
            if (byte_pulse === 1'b1) q.push_back(rd_data);
        end
        if (i == 3000) begin
            failures++;
            end_of_test();
        end
        // Let the device see select low before anything else is judged or started.
        repeat (4) @(negedge clock);
        chk("busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_write_all();
        for (int r = 0; r < 16; r++) begin
            xfer({RTSP_DIR_WRITE, RTSP_SUB_VALID, 4'(r)}, 4'h1, pat(r));
            chk("frozen seen", 8'h01, {7'h00, frz_seen});
            chk("bytes", 8'h02, 8'(q.size()));
        end
        for (int r = 0; r < 16; r++) reg_chk(r, pat(r));
        $display("test write_all done");
    endtask
    task automatic t_read_wrap();
        xfer({RTSP_DIR_READ, RTSP_SUB_VALID, 4'he}, 4'h4, 8'h00);
        for (int k = 0; k < 4; k++) chk("read byte", pat((14 + k) % 16), q[k + 1]);
        chk("frozen after", 8'h00, {7'h00, counting_frozen});
        $display("test read_wrap done");
    endtask
    task automatic t_write_wrap();
        xfer({RTSP_DIR_WRITE, RTSP_SUB_VALID, 4'hf}, 4'h3, 8'h3c);
        reg_chk(15, 8'h3c);
        reg_chk(1, 8'h3c);
        reg_chk(2, pat(2));
        $display("test write_wrap done");
    endtask
    task automatic t_bad_sub();
        for (int s = 0; s < 8; s++) begin
            if (s == 1) continue;
            xfer({RTSP_DIR_WRITE, 3'(s), 4'h3}, 4'h1, 8'hff);
            reg_chk(3, pat(3));
            chk("frozen seen", 8'h00, {7'h00, frz_seen});
        end
        $display("test bad_sub done");
    endtask
    task automatic t_abort();
        @(negedge clock);
        start = 1'b1;
        cmd_byte = {RTSP_DIR_WRITE, RTSP_SUB_VALID, 4'h5};
        data_count = 4'h1;
        @(negedge clock);
        start = 1'b0;
        repeat (100) @(negedge clock);
        host_rstn = 1'b0;
        @(negedge clock);
        host_rstn = 1'b1;
        reg_chk(5, pat(5));
        xfer({RTSP_DIR_WRITE, RTSP_SUB_VALID, 4'h5}, 4'h1, 8'h5a);
        reg_chk(5, 8'h5a);
        $display("test abort done");
    endtask
    task automatic t_wdog();
        wd_cnt = 0;
        xfer({RTSP_DIR_READ, RTSP_SUB_VALID, 4'h0}, 4'hf, 8'h00);
        chk("watchdog pulses", 8'h01, 8'(wd_cnt));
        xfer({RTSP_DIR_READ, RTSP_SUB_VALID, 4'hf}, 4'h1, 8'h00);
        chk("read after", 8'h3c, q[1]);
        $display("test wdog done");
    endtask
    initial begin
        {resetn, host_rstn, start, cmd_byte, data_count, wr_data, user_rd_index} = '0;
        frz_seen = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        host_rstn = 1'b1;
        t_write_all();
        t_read_wrap();
        t_write_wrap();
        t_bad_sub();
        t_abort();
        t_wdog();
        end_of_test();
    end
endmodule : tb_top
